//--- src/moi_pkg.sv
// Purpose: Shared constants, types and helpers for the move/or instruction decoder.
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file register address.
// Notes: Overview of operation follows.
// Overview of operation
// - File move with destination clear loads work
// - File move with destination set rewrites file
// - File move updates zero flag from value
// - Literal load sets work, flags untouched
// - Literal load ignores its two don't-care bits
// - Store writes work to file, flags untouched
package moi_pkg;

    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int FILE_DEPTH = 128;

    // Field positions inside an instruction word
    localparam int OPC_HI = 13;
    localparam int OPC_LO = 8;
    localparam int DEST_BIT = 7;
    localparam int FADDR_HI = 6;
    localparam int LIT_HI = 7;

    // Upper six bits of each recognised opcode
    localparam logic [5:0] OPC_OR = 6'h04;
    localparam logic [5:0] OPC_MOVE = 6'h08;
    localparam logic [5:0] OPC_STORE = 6'h00;
    localparam logic [5:0] OPC_LIT = 6'h30;
    localparam logic [5:0] OPC_LIT_MASK = 6'h3C;

    // Reset values
    localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
    localparam logic ZERO_RST = 1'b0;
    localparam logic [INSTR_W-1:0] INSTR_RST = 14'h0000;

    typedef enum logic [1:0] {
        MOI_ST_IDLE = 2'b00,
        MOI_ST_READ = 2'b01,
        MOI_ST_EXEC = 2'b10
    } moi_state_t;

    typedef enum logic [2:0] {
        MOI_OP_NONE = 3'b000,
        MOI_OP_OR = 3'b001,
        MOI_OP_MOVE = 3'b010,
        MOI_OP_LIT = 3'b011,
        MOI_OP_STORE = 3'b100
    } moi_op_t;

    function automatic moi_op_t moi_decode(input logic [INSTR_W-1:0] instr);
        logic [5:0] opc;
        opc = instr[OPC_HI:OPC_LO];
        if ((opc & OPC_LIT_MASK) == OPC_LIT) begin
            moi_decode = MOI_OP_LIT;
        end else if (opc == OPC_OR) begin
            moi_decode = MOI_OP_OR;
        end else if (opc == OPC_MOVE) begin
            moi_decode = MOI_OP_MOVE;
        end else if (opc == OPC_STORE && instr[DEST_BIT]) begin
            moi_decode = MOI_OP_STORE;
        end else begin
            moi_decode = MOI_OP_NONE;
        end
    endfunction

    function automatic logic moi_is_zero(input logic [DATA_W-1:0] value);
        moi_is_zero = (value == '0);
    endfunction

endpackage

//--- src/moi_file_if.sv
// Purpose: Carrier between the decoder and its file register memory.
// Assumes: One read port with registered data, one write port, same clock.
// Notes: Read data lags the read address by one enabled edge.
`timescale 1ns/1ps
`default_nettype none
interface moi_file_if;
    import moi_pkg::*;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;

    modport core (
        output rd_addr,
        input rd_data,
        output wr_en,
        output wr_addr,
        output wr_data
    );

    modport mem (
        input rd_addr,
        output rd_data,
        input wr_en,
        input wr_addr,
        input wr_data
    );
endinterface
`default_nettype wire

//--- src/moi_file_ram.sv
// Purpose: File register space, 128 bytes, registered read data.
// Assumes: Single clock; clock enable freezes both ports.
// Notes: Contents are not reset; software must write before reading.
`timescale 1ns/1ps
`default_nettype none
module moi_file_ram
    import moi_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_ce,
    moi_file_if.mem fr
);

    logic [DATA_W-1:0] mem [FILE_DEPTH];

    // Read returns old data on a same-address write; the decoder overlaps them only in EXEC, whose read data is then unused
    always_ff @(posedge i_core_clk) begin
        if (i_ce) begin
            if (fr.wr_en) begin
                mem[fr.wr_addr] <= fr.wr_data;
            end
            fr.rd_data <= mem[fr.rd_addr];
        end
    end

endmodule
`default_nettype wire

//--- src/moi_decoder.sv
// Purpose: Decode and execute OR, file move, literal load and store instructions.
// Assumes: Instruction words arrive on a valid/ready handshake in the core clock domain.
// Notes: Each accepted word takes three enabled cycles; other opcodes are ignored.
`timescale 1ns/1ps
`default_nettype none
module moi_decoder
    import moi_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic [INSTR_W-1:0] i_instr,
    input wire logic i_instr_valid,
    output logic o_instr_ready,
    output logic [DATA_W-1:0] o_work,
    output logic o_zero,
    output logic o_done,
    output logic o_ignored,
    output logic o_file_wr,
    output logic [ADDR_W-1:0] o_file_addr,
    output logic [DATA_W-1:0] o_file_data
);

    typedef struct packed {
        moi_state_t state;
        logic [INSTR_W-1:0] instr;
        logic [DATA_W-1:0] work;
        logic zero;
        logic done;
        logic ignored;
        logic file_wr;
        logic [ADDR_W-1:0] file_addr;
        logic [DATA_W-1:0] file_data;
    } moi_regs_t;

    localparam moi_regs_t REGS_RST = '{
        state: MOI_ST_IDLE,
        instr: INSTR_RST,
        work: WORK_RST,
        zero: ZERO_RST,
        done: 1'b0,
        ignored: 1'b0,
        file_wr: 1'b0,
        file_addr: '0,
        file_data: '0
    };

    moi_regs_t r;
    moi_regs_t next_r;
    moi_op_t op;
    logic [DATA_W-1:0] result;
    logic [ADDR_W-1:0] faddr;
    logic dest_file;

    moi_file_if fr();

    moi_file_ram u_file_ram (
        .i_core_clk(i_core_clk),
        .i_ce(i_ce),
        .fr(fr.mem)
    );

    // Fields of the held instruction
    assign op = moi_decode(r.instr);
    assign faddr = r.instr[FADDR_HI:0];
    assign dest_file = r.instr[DEST_BIT];

    always_comb begin
        next_r = r;
        result = '0;
        // Address held steady so registered read data lines up with EXEC
        fr.rd_addr = faddr;
        fr.wr_en = 1'b0;
        fr.wr_addr = faddr;
        fr.wr_data = '0;
        if (i_ce) begin
            // Pulses drop only on enabled edges; a frozen cycle must hold them
            next_r.done = 1'b0;
            next_r.ignored = 1'b0;
            next_r.file_wr = 1'b0;
            unique case (r.state)
                MOI_ST_IDLE: begin
                    if (i_instr_valid) begin
                        next_r.instr = i_instr;
                        next_r.state = MOI_ST_READ;
                    end
                end
                MOI_ST_READ: begin
                    next_r.state = MOI_ST_EXEC;
                end
                MOI_ST_EXEC: begin
                    unique case (op)
                        MOI_OP_OR: begin
                            result = r.work | fr.rd_data;
                            next_r.zero = moi_is_zero(result);
                            if (dest_file) begin
                                fr.wr_en = 1'b1;
                                fr.wr_data = result;
                            end else begin
                                next_r.work = result;
                            end
                        end
                        MOI_OP_MOVE: begin
                            result = fr.rd_data;
                            next_r.zero = moi_is_zero(result);
                            if (dest_file) begin
                                // Rewrite to itself; useful purely as a zero test
                                fr.wr_en = 1'b1;
                                fr.wr_data = result;
                            end else begin
                                next_r.work = result;
                            end
                        end
                        MOI_OP_LIT: begin
                            // Zero flag deliberately left alone
                            result = r.instr[LIT_HI:0];
                            next_r.work = result;
                        end
                        MOI_OP_STORE: begin
                            // No flag update on a plain store
                            result = r.work;
                            fr.wr_en = 1'b1;
                            fr.wr_data = result;
                        end
                        MOI_OP_NONE: begin
                            // Other opcodes belong to neighbouring logic
                            next_r.ignored = 1'b1;
                        end
                    endcase
                    next_r.file_wr = fr.wr_en;
                    next_r.file_addr = faddr;
                    next_r.file_data = fr.wr_data;
                    next_r.done = 1'b1;
                    next_r.state = MOI_ST_IDLE;
                end
                default: begin
                    // Unused state code recovers to idle
                    next_r.state = MOI_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            r <= REGS_RST;
        end else begin
            r <= next_r;
        end
    end

    // Ready only in idle, and never while frozen
    assign o_instr_ready = i_ce && (r.state == MOI_ST_IDLE);
    assign o_work = r.work;
    assign o_zero = r.zero;
    assign o_done = r.done;
    assign o_ignored = r.ignored;
    assign o_file_wr = r.file_wr;
    assign o_file_addr = r.file_addr;
    assign o_file_data = r.file_data;

endmodule
`default_nettype wire

//--- tb/moi_prog_model.sv
// Purpose: Program memory side handing words to the decoder.
// Assumes: A word is held until an edge that sees ready high.
// Notes: Released bus shows the inverted word, never a stale copy.
`timescale 1ns/1ps
`default_nettype none
module moi_prog_model (
    input wire logic i_core_clk,
    input wire logic i_ready,
    output logic o_valid,
    output logic [13:0] o_instr
);
    initial begin
        o_valid = 1'b0;
        o_instr = 14'h0000;
    end
    task automatic send(input logic [13:0] word);
        o_valid = 1'b1;
        o_instr = word;
        do @(negedge i_core_clk); while (!i_ready);
        @(posedge i_core_clk);
        #1;
        o_valid = 1'b0;
        o_instr = ~word;
    endtask
endmodule
`default_nettype wire

//--- tb/moi_decoder_sva.sv
// Purpose: Port-level checks for the move/or decoder.
// Assumes: Word, work and zero are captured at the accepting edge.
// Notes: Bound into every decoder instance.
`timescale 1ns/1ps
`default_nettype none
module moi_decoder_sva
    import moi_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic [INSTR_W-1:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic o_instr_ready,
    input wire logic [DATA_W-1:0] o_work,
    input wire logic o_zero,
    input wire logic o_done,
    input wire logic o_ignored,
    input wire logic o_file_wr,
    input wire logic [ADDR_W-1:0] o_file_addr,
    input wire logic [DATA_W-1:0] o_file_data
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    typedef struct packed {logic [INSTR_W-1:0] word; logic [DATA_W-1:0] w; logic z;} moi_cap_t;
    moi_cap_t cap;
    moi_cap_t next_cap;
    logic acc;
    logic lit;
    logic alu;
    assign acc = i_ce && i_instr_valid && o_instr_ready;
    assign lit = o_done && (cap.word[13:8] & OPC_LIT_MASK) == OPC_LIT;
    assign alu = o_done && (cap.word[13:8] == OPC_OR || cap.word[13:8] == OPC_MOVE);
    always_comb begin
        next_cap = cap;
        if (acc) begin
            next_cap = '{i_instr, o_work, o_zero};
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            cap <= '0;
        end else begin
            cap <= next_cap;
        end
    end
    a_ready_needs_ce:
        assert property (o_instr_ready |-> i_ce) else $error("ready without enable");
    a_busy_after_accept:
        assert property (acc |=> !o_instr_ready) else $error("ready during execution");
    a_done_three_edges:
        assert property (acc ##1 i_ce [*2] |=> o_done) else $error("done not after three edges");
    a_done_single_cycle:
        assert property (o_done && i_ce |=> !o_done) else $error("done longer than one cycle");
    a_lit_loads_work:
        assert property (lit |-> o_work == cap.word[7:0] && o_zero == cap.z && !o_file_wr) else $error("literal load");
    a_store_writes_file:
        assert property (o_done && cap.word[13:7] == 7'h01 |-> o_file_wr && o_file_addr == cap.word[6:0]
            && o_file_data == cap.w && o_zero == cap.z) else $error("store to file");
    a_zero_from_result:
        assert property (alu |-> o_zero == ((cap.word[7] ? o_file_data : o_work) == 8'h00)) else $error("zero flag");
    a_dest_selects:
        assert property (alu |-> o_file_wr == cap.word[7] && (!cap.word[7] || o_work == cap.w)) else $error("dest");
    a_or_keeps_bits:
        assert property (o_done && cap.word[13:7] == 7'h08 |-> (o_work & cap.w) == cap.w) else $error("or result");
    a_ignored_quiet:
        assert property (o_ignored |-> o_done && !o_file_wr && o_work == cap.w && o_zero == cap.z)
            else $error("ignored word acted");
    a_frozen_holds:
        assert property (!i_ce |=> $stable(o_work) && $stable(o_zero) && $stable(o_done) && $stable(o_file_wr))
            else $error("state moved while frozen");
endmodule
bind moi_decoder moi_decoder_sva u_moi_decoder_sva (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_instr(i_instr), .i_instr_valid(i_instr_valid), .o_instr_ready(o_instr_ready), .o_work(o_work),
    .o_zero(o_zero), .o_done(o_done), .o_ignored(o_ignored), .o_file_wr(o_file_wr),
    .o_file_addr(o_file_addr), .o_file_data(o_file_data));
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the move/or decoder.
// Assumes: Only file addresses 0..7 are used, all stored before being read.
// Notes: Clock enable drops at random to stretch execution.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_core_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_ce = 1'b1;
    logic i_instr_valid, o_instr_ready, o_zero, o_done, o_ignored, o_file_wr, ewr, eig;
    logic z = 1'b0;
    logic [13:0] i_instr;
    logic [6:0] o_file_addr;
    logic [7:0] o_work, o_file_data, mem [8];
    logic [7:0] w = 8'h00;
    logic [13:0] corner [6] = '{14'h3300, 14'h0081, 14'h0881, 14'h0802, 14'h0401, 14'h0000};
    integer seed = 32'ha2be;
    int n_mismatch = 0, comparisons = 0, cycles = 0;
    moi_decoder u_moi_decoder (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_ce(i_ce), .i_instr(i_instr),
        .i_instr_valid(i_instr_valid), .o_instr_ready(o_instr_ready), .o_work(o_work), .o_zero(o_zero),
        .o_done(o_done), .o_ignored(o_ignored), .o_file_wr(o_file_wr), .o_file_addr(o_file_addr),
        .o_file_data(o_file_data));
    moi_prog_model u_moi_prog_model (.i_core_clk(i_core_clk), .i_ready(o_instr_ready), .o_valid(i_instr_valid),
        .o_instr(i_instr));
    initial forever #4 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        #1 i_ce = ($random(seed) & 7) != 0;
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [13:0] word);
        logic [7:0] r;
        int k;
        r = word[13:8] == 6'h04 ? (w | mem[word[2:0]]) : mem[word[2:0]];
        ewr = 1'b0;
        eig = 1'b0;
        if (word[13:10] == 4'hC) begin
            w = word[7:0];
        end else if (word[13:8] == 6'h04 || word[13:8] == 6'h08) begin
            z = r == 8'h00;
            ewr = word[7];
            if (word[7]) mem[word[2:0]] = r;
            else w = r;
        end else if (word[13:7] == 7'h01) begin
            ewr = 1'b1;
            mem[word[2:0]] = w;
        end else begin
            eig = 1'b1;
        end
        u_moi_prog_model.send(word);
        k = 0;
        do begin
            @(negedge i_core_clk);
            k++;
        end while (o_done !== 1'b1 && k < 40);
        chk({7'h00, o_done}, 8'h01);
        chk(o_work, w);
        chk({7'h00, o_zero}, {7'h00, z});
        chk({6'h00, o_file_wr, o_ignored}, {6'h00, ewr, eig});
        if (ewr) chk(o_file_data, mem[word[2:0]]);
        if (ewr) chk({1'b0, o_file_addr}, {1'b0, word[6:0]});
        @(posedge i_core_clk);
        #1;
    endtask
    initial begin
        logic [13:0] word;
        logic [17:0] r;
        repeat (6) @(posedge i_core_clk);
        #1 i_reset = 1'b0;
        for (int a = 0; a < 8; a++) begin
            run({6'h30, 8'($random(seed))});
            run({7'h01, 7'(a)});
        end
        foreach (corner[i]) run(corner[i]);
        // Mid-run reset: registers clear, file contents survive
        i_reset = 1'b1;
        @(posedge i_core_clk);
        #1 i_reset = 1'b0;
        @(negedge i_core_clk);
        chk(o_work, 8'h00);
        chk({4'h0, o_zero, o_done, o_ignored, o_file_wr}, 8'h00);
        chk(o_file_data, 8'h00);
        w = 8'h00;
        z = 1'b0;
        @(posedge i_core_clk);
        #1;
        repeat (100) begin
            r = 18'($random(seed));
            word = r[13:0];
            if (r[16:14] != 3'h0) word[6:3] = 4'h0;
            case (r[16:14])
                3'h0: word[13:10] = 4'hC;
                3'h1: word[13:7] = 7'h01;
                3'h2: word[13:8] = 6'h08;
                3'h3: word[13:8] = 6'h04;
                default: word[13:7] = {5'h00, r[17], 1'b0};
            endcase
            run(word);
        end
        finish_test();
    end
endmodule
`default_nettype wire
